// >>> src/tsirq_map.vh
`ifndef TSIRQ_MAP_VH
`define TSIRQ_MAP_VH
// Register word addresses on the Avalon word bus (address is word index).
`define TSIRQ_ADR_CFG 4'h0
`define TSIRQ_ADR_STAT 4'h1
`define TSIRQ_ADR_MASK 4'h2
`define TSIRQ_ADR_EVT 4'h3
`define TSIRQ_ADR_CLR 4'h4
`define TSIRQ_ADR_SLOTCFG 4'h8
// Config register fields.
`define TSIRQ_CFG_ARB_LSB 0
`define TSIRQ_CFG_ARB_MSB 2
`define TSIRQ_CFG_VEC_LSB 6
`define TSIRQ_CFG_VEC_MSB 7
// Per-slot config fields.
`define TSIRQ_SC_LVL_LSB 0
`define TSIRQ_SC_LVL_MSB 2
`define TSIRQ_SC_TOP 3
// Slot range and count.
`define TSIRQ_SLOT_FIRST 2
`define TSIRQ_SLOT_LAST 31
`define TSIRQ_NSLOT 32
`define TSIRQ_SLOT_RTC 16
// Status bits.
`define TSIRQ_ST_ACK 0
`define TSIRQ_ST_NOWIN 1
`define TSIRQ_NSTAT 2
// Reset values.
`define TSIRQ_RST_CFG 8'h00
`define TSIRQ_RST_SLOTCFG 4'h0
`define TSIRQ_RST_MASK 2'h0
`define TSIRQ_LVL_OFF 3'h0
`endif

// >>> src/tsirq_ctrl.v
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "tsirq_map.vh"
module tsirq_ctrl (
	// Clock and reset.
	input wire core_clk,
	input wire sys_rst,
	// Avalon-MM slave.
	input wire [5:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	// Submodule event pulses, one per slot, from the same clock domain.
	input wire [31:0] slot_event,
	// Intermodule bus request lines, bit n-1 is level n.
	output reg [6:0] irq_level_lines,
	// Arbitration cycle from the processor-side arbiter.
	input wire arb_start,
	input wire [2:0] arb_level,
	input wire [3:0] arb_number,
	// Answer of this block.
	output reg arb_respond,
	output reg [3:0] arb_priority,
	output reg [7:0] vector_out,
	output reg vector_valid,
	// Interrupt output.
	output wire irq
);
	reg [7:0] cfg_r;
	reg [3:0] slot_cfg_r [0:`TSIRQ_NSLOT-1];
	reg [31:0] flag_a_r;
	reg [31:0] flag_b_r;
	reg [`TSIRQ_NSTAT-1:0] stat_r;
	reg [`TSIRQ_NSTAT-1:0] mask_r;
	reg ack_phase_r;
	reg rd_ack_r;
	reg [31:0] pend;
	reg [31:0] cand;
	reg [4:0] win_slot;
	reg win_found;
	reg win_src_b;
	reg [6:0] lines_nxt;
	integer i;
	wire wr = avs_write;
	wire [3:0] reg_idx = avs_address[3:0];
	wire slot_space = avs_address[5];
	wire [4:0] slot_idx = avs_address[4:0];
	// Second source B event is the slot's own data bit of a write to the event register only, for simplicity.
	wire evt_wr = wr && !slot_space && (reg_idx == `TSIRQ_ADR_EVT);
	wire clr_wr = wr && !slot_space && (reg_idx == `TSIRQ_ADR_CLR);

	// Reads take one wait state so the registered read data stands when waitrequest drops.
	// Writes need none and land at the edge that presents them.
	assign avs_waitrequest = avs_read && !rd_ack_r;
	assign irq = |(stat_r & mask_r);

	// Source flags; the set beats a same-cycle clear so no event is lost.
	genvar g;
	generate
		for (g = 0; g < `TSIRQ_NSLOT; g = g + 1) begin : g_slot
			wire usable = (g >= `TSIRQ_SLOT_FIRST);
			always @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst) begin
					flag_a_r[g] <= 1'b0;
					flag_b_r[g] <= 1'b0;
					slot_cfg_r[g] <= `TSIRQ_RST_SLOTCFG;
				end else begin
					if (usable && slot_event[g])
						flag_a_r[g] <= 1'b1;
					else if (clr_wr && avs_writedata[g])
						flag_a_r[g] <= 1'b0;
					if (usable && evt_wr && avs_writedata[g])
						flag_b_r[g] <= 1'b1;
					else if (clr_wr && avs_writedata[g] && avs_writedata[31])
						flag_b_r[g] <= 1'b0;
					if (wr && slot_space && slot_idx == g && usable)
						slot_cfg_r[g] <= avs_writedata[3:0];
				end
			end
		end
	endgenerate

	// Pending slots and request level lines.
	always @* begin
		pend = 32'h00000000;
		lines_nxt = 7'h00;
		for (i = `TSIRQ_SLOT_FIRST; i < `TSIRQ_NSLOT; i = i + 1) begin
			if ((flag_a_r[i] || flag_b_r[i]) &&
			    slot_cfg_r[i][`TSIRQ_SC_LVL_MSB:`TSIRQ_SC_LVL_LSB] != `TSIRQ_LVL_OFF) begin
				pend[i] = 1'b1;
				lines_nxt[slot_cfg_r[i][2:0] - 3'h1] = 1'b1;
			end
		end
	end

	// Candidate set: pending at the arbitrated level and matching arbitration number.
	always @* begin
		cand = 32'h00000000;
		for (i = `TSIRQ_SLOT_FIRST; i < `TSIRQ_NSLOT; i = i + 1) begin
			if (pend[i] && slot_cfg_r[i][2:0] == arb_level &&
			    {slot_cfg_r[i][`TSIRQ_SC_TOP], cfg_r[`TSIRQ_CFG_ARB_MSB:`TSIRQ_CFG_ARB_LSB]} == arb_number)
				cand[i] = 1'b1;
		end
	end

	// Lowest slot wins; scanning downward leaves the lowest match last.
	always @* begin
		win_slot = 5'h00;
		win_found = 1'b0;
		win_src_b = 1'b0;
		for (i = `TSIRQ_SLOT_LAST; i >= `TSIRQ_SLOT_FIRST; i = i - 1) begin
			if (cand[i]) begin
				win_slot = i[4:0];
				win_found = 1'b1;
				win_src_b = !flag_a_r[i];
			end
		end
	end

	// Arbitration answer is captured at the start pulse and held one cycle.
	// Sampling once at start keeps late requests out of this cycle's vector.
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			arb_respond <= 1'b0;
			arb_priority <= 4'h0;
			vector_out <= 8'h00;
			vector_valid <= 1'b0;
			irq_level_lines <= 7'h00;
			ack_phase_r <= 1'b0;
		end else begin
			irq_level_lines <= lines_nxt;
			ack_phase_r <= arb_start;
			vector_valid <= 1'b0;
			arb_respond <= 1'b0;
			if (arb_start && win_found) begin
				arb_respond <= 1'b1;
				arb_priority <= {slot_cfg_r[win_slot][`TSIRQ_SC_TOP],
					cfg_r[`TSIRQ_CFG_ARB_MSB:`TSIRQ_CFG_ARB_LSB]};
				// Source B is told apart by flipping bit 5, unused by slot numbers.
				vector_out <= {cfg_r[`TSIRQ_CFG_VEC_MSB:`TSIRQ_CFG_VEC_LSB], win_src_b, win_slot};
				vector_valid <= 1'b1;
			end
		end
	end

	// Software registers and sticky status.
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_r <= `TSIRQ_RST_CFG;
			mask_r <= `TSIRQ_RST_MASK;
			stat_r <= {`TSIRQ_NSTAT{1'b0}};
		end else begin
			if (wr && !slot_space && reg_idx == `TSIRQ_ADR_CFG)
				cfg_r <= avs_writedata[7:0];
			if (wr && !slot_space && reg_idx == `TSIRQ_ADR_MASK)
				mask_r <= avs_writedata[`TSIRQ_NSTAT-1:0];
			for (i = 0; i < `TSIRQ_NSTAT; i = i + 1) begin
				if (wr && !slot_space && reg_idx == `TSIRQ_ADR_STAT && avs_writedata[i])
					stat_r[i] <= 1'b0;
			end
			if (arb_start && win_found)
				stat_r[`TSIRQ_ST_ACK] <= 1'b1;
			if (arb_start && !win_found && |lines_nxt)
				stat_r[`TSIRQ_ST_NOWIN] <= 1'b1;
		end
	end

	// Read data registered in the wait state; the master takes it when waitrequest is low.
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_readdata <= 32'h00000000;
			rd_ack_r <= 1'b0;
		end else begin
			rd_ack_r <= avs_read && !rd_ack_r;
			if (avs_read && !rd_ack_r) begin
				if (slot_space) begin
					avs_readdata <= {28'h0000000, slot_cfg_r[slot_idx]};
				end else begin
					case (reg_idx)
						`TSIRQ_ADR_CFG: begin
							avs_readdata <= {24'h000000, cfg_r};
						end
						`TSIRQ_ADR_STAT: begin
							avs_readdata <= {30'h0000000, stat_r};
						end
						`TSIRQ_ADR_MASK: begin
							avs_readdata <= {30'h0000000, mask_r};
						end
						`TSIRQ_ADR_EVT: begin
							avs_readdata <= flag_b_r;
						end
						`TSIRQ_ADR_CLR: begin
							avs_readdata <= flag_a_r;
						end
						default: begin
							avs_readdata <= 32'h00000000;
						end
					endcase
				end
			end
		end
	end
endmodule // tsirq_ctrl

// >>> dv/tsirq_arb_model.sv
`timescale 1ns/1ps
module tsirq_arb_model (
	// Clock.
	input wire core_clk,
	// Arbitration cycle towards the block.
	output reg arb_start,
	output reg [2:0] arb_level,
	output reg [3:0] arb_number
);
	initial begin
		arb_start = 1'b0;
		arb_level = 3'h0;
		arb_number = 4'h0;
	end
	// Level and number only count with the start pulse, so they are scrambled after it.
	task run(input [2:0] lvl, input [3:0] num);
		arb_start <= 1'b1;
		arb_level <= lvl;
		arb_number <= num;
		@(posedge core_clk);
		arb_start <= 1'b0;
		arb_level <= ~lvl;
		arb_number <= ~num;
	endtask
endmodule // tsirq_arb_model

// >>> dv/tsirq_chk.sv
`timescale 1ns/1ps
module tsirq_chk (
	// Clock and reset.
	input wire core_clk,
	input wire sys_rst,
	// Arbitration side.
	input wire [6:0] irq_level_lines,
	input wire arb_start,
	input wire [3:0] arb_number,
	input wire arb_respond,
	input wire [3:0] arb_priority,
	input wire [7:0] vector_out,
	input wire vector_valid
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_win;
		arb_start ##1 arb_respond;
	endsequence
	pair_a: assert property (arb_respond == vector_valid) else $error("valid split");
	cause_a: assert property (arb_respond |-> $past(arb_start)) else $error("no start");
	number_a: assert property (arb_respond |-> arb_priority == $past(arb_number)) else $error("bad prio");
	pend_a: assert property (arb_respond |-> $past(irq_level_lines) != 7'h00) else $error("no line");
	slot_a: assert property (vector_valid |-> vector_out[4:0] > 5'h01) else $error("bad slot");
	vec_hold_a: assert property ($changed(vector_out) |-> arb_respond) else $error("vec moved");
	prio_hold_a: assert property ($changed(arb_priority) |-> arb_respond) else $error("prio moved");
	one_win_a: assert property (s_win ##1 !arb_start |=> !arb_respond) else $error("long win");
	quiet_bus_a: assert property (!arb_start |=> !arb_respond) else $error("stray respond");
endmodule // tsirq_chk
bind tsirq_ctrl tsirq_chk i_tsirq_chk (.core_clk, .sys_rst, .irq_level_lines, .arb_start, .arb_number,
	.arb_respond, .arb_priority, .vector_out, .vector_valid);

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	reg core_clk = 1'b0;
	reg sys_rst = 1'b1;
	reg [5:0] avs_address = 6'h00;
	reg avs_read = 1'b0;
	reg avs_write = 1'b0;
	reg [31:0] avs_writedata = 32'h00000000;
	reg [31:0] slot_event = 32'h00000000;
	reg [31:0] rd_q = 32'h00000000;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, arb_start, arb_respond, vector_valid, irq;
	wire [2:0] arb_level;
	wire [3:0] arb_number, arb_priority;
	wire [6:0] irq_level_lines;
	wire [7:0] vector_out;
	integer num_errors = 0, checks_done = 0, i, k;
	reg [8:0] rows [0:2];
	always #50 core_clk = ~core_clk;
	tsirq_ctrl i_tsirq_ctrl (.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .slot_event, .irq_level_lines, .arb_start, .arb_level, .arb_number, .arb_respond,
		.arb_priority, .vector_out, .vector_valid, .irq);
	tsirq_arb_model i_tsirq_arb_model (.core_clk, .arb_start, .arb_level, .arb_number);
	task chk(input [63:0] what, input [31:0] exp, input [31:0] got);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("MISMATCH %0s exp %h got %h", what, exp, got);
		end
	endtask
	task print_verdict;
		if (num_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// An idle edge ends every transfer, so strobes are never driven twice in one step.
	task bus(input wr, input [5:0] a, input [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		k = 0;
		do begin
			@(posedge core_clk);
			k = k + 1;
		end while (avs_waitrequest !== 1'b0 && k < 20);
		rd_q = avs_readdata;
		if (k == 20) begin
			num_errors = num_errors + 1;
			print_verdict;
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask
	task pulse(input [31:0] ev);
		slot_event <= ev;
		@(posedge core_clk);
		slot_event <= 32'h00000000;
		repeat (2) @(posedge core_clk);
	endtask
	task arb(input [2:0] lvl, input [3:0] num, input rsp, input [7:0] vec);
		i_tsirq_arb_model.run(lvl, num);
		slot_event <= 32'h00000000;
		@(negedge core_clk);
		chk("respond", rsp, arb_respond);
		chk("vector", vec, vector_out);
		chk("valid", rsp, vector_valid);
		if (rsp)
			chk("prio", num, arb_priority);
		@(posedge core_clk);
	endtask
	initial begin
		rows[0] = 9'h021;
		rows[1] = 9'h10F;
		rows[2] = 9'h1F4;
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(negedge core_clk);
		chk("reset", 32'h00000000, {vector_out, irq_level_lines, arb_respond, irq});
		@(posedge core_clk);
		bus(1'b1, 6'h00, 32'h00000085);
		for (i = 0; i < 3; i = i + 1) begin
			bus(1'b1, {1'b1, rows[i][8:4]}, {28'h0000000, rows[i][3:0]});
			pulse(32'h00000001 << rows[i][8:4]);
			chk("lines", 32'h00000001 << (rows[i][2:0] - 3'h1), irq_level_lines);
			arb(rows[i][2:0], {rows[i][3], 3'h5}, 1'b1, {3'h4, rows[i][8:4]});
			bus(1'b1, 6'h04, 32'h00000001 << rows[i][8:4]);
			@(posedge core_clk);
			chk("cleared", 32'h00000000, irq_level_lines);
		end
		pulse(32'h00000022);
		chk("silent", 32'h00000000, irq_level_lines);
		bus(1'b1, 6'h22, 32'h00000003);
		bus(1'b1, 6'h24, 32'h00000003);
		bus(1'b1, 6'h29, 32'h00000003);
		pulse(32'h00000210);
		slot_event <= 32'h00000004;
		arb(3'h3, 4'h5, 1'b1, 8'h84);
		arb(3'h3, 4'hD, 1'b0, 8'h84);
		bus(1'b0, 6'h04, 32'h00000000);
		chk("flags", 32'h00000234, rd_q);
		bus(1'b1, 6'h04, 32'h00000234);
		bus(1'b1, 6'h03, 32'h00000200);
		arb(3'h3, 4'h5, 1'b1, 8'hA9);
		bus(1'b1, 6'h04, 32'h80000200);
		bus(1'b1, 6'h02, 32'h00000001);
		chk("irq", 32'h00000001, irq);
		bus(1'b1, 6'h01, 32'h00000001);
		chk("irq_clr", 32'h00000000, irq);
		bus(1'b0, 6'h0F, 32'h00000000);
		chk("unmapped", 32'h00000000, rd_q);
		print_verdict;
	end
endmodule // tb_top
